// ### rtl/mss_pkg.sv
// Purpose: constants and types for the motor start-up sequencer
// Assumes: one 50 MHz control clock; angles are 16 bit, 65536 = 360 deg
package mss_pkg;

  localparam logic [1:0] MSS_SEL_ALIGN = 2'h0;
  localparam logic [1:0] MSS_SEL_DALIGN = 2'h1;
  localparam logic [1:0] MSS_SEL_PROBE = 2'h2;
  localparam logic [1:0] MSS_SEL_SLOW = 2'h3;
  localparam logic MSS_REL_RECIRC = 1'b0;
  localparam logic [15:0] MSS_ANGLE_90 = 16'h4000;
  localparam logic [2:0] MSS_PAT_LAST = 3'h5;

  // pattern current vector angle, index 0..5 = BC CB AB BA CA AC
  localparam logic [5:0][15:0] MSS_PAT_ANGLE = {
    16'h1555, 16'h9555, 16'h6aaa, 16'heaaa, 16'hc000, 16'h4000};
  // high switches {c,b,a} per pattern
  localparam logic [5:0][2:0] MSS_PAT_HIGH = {
    3'h1, 3'h4, 3'h2, 3'h1, 3'h4, 3'h2};
  // low switches {c,b,a} per pattern
  localparam logic [5:0][2:0] MSS_PAT_LOW = {
    3'h4, 3'h1, 3'h1, 3'h2, 3'h2, 3'h4};

  localparam int MSS_CLK_NS = 20;
  localparam int MSS_OL_TICK_NS = 1000000;
  localparam int MSS_OL_TICK_CYC = MSS_OL_TICK_NS / MSS_CLK_NS;
  localparam int MSS_IQ_DECAY_SHIFT = 4;

  typedef enum logic [3:0] {
    MSS_IDLE = 4'h0,
    MSS_ALIGN1 = 4'h1,
    MSS_ALIGN2 = 4'h2,
    MSS_PDRIVE = 4'h3,
    MSS_PWAIT = 4'h4,
    MSS_SLOW = 4'h5,
    MSS_OPEN = 4'h6,
    MSS_DECAY = 4'h7,
    MSS_CLSLOW = 4'h8,
    MSS_CLRUN = 4'h9
  } mss_state_t;

  typedef struct packed {
    logic [1:0] startup_method_select;
    logic probe_release_select;
    logic [15:0] probe_pattern_rate;
    logic [11:0] probe_current_threshold;
    logic [15:0] probe_drive_advance_angle;
    logic [15:0] align_angle;
    logic [15:0] align_time;
    logic [11:0] align_current;
    logic [15:0] first_cycle_speed;
    logic [11:0] open_loop_current_limit;
    logic [15:0] open_loop_accel_linear_coef;
    logic [15:0] open_loop_accel_quadratic_coef;
    logic auto_handoff_enable;
    logic [15:0] handoff_speed_threshold;
    logic torque_current_ramp_enable;
    logic [15:0] theta_error_ramp_rate;
    logic [15:0] closed_loop_slow_accel;
  } mss_cfg_t;

  typedef struct packed {
    logic [2:0] high;
    logic [2:0] low;
  } mss_gate_t;

endpackage : mss_pkg

// ### rtl/mss_top.sv
// Purpose: start-up sequencer: align, probing, slow cycle, open loop, handoff
// Assumes: phase current, speed and angle inputs come from same-clock logic
// Notes: speed units are angle lsb per clock / 65536; ticks are OL_TICK_CYC
module mss_top #(
  parameter int OL_TICK_CYC = mss_pkg::MSS_OL_TICK_CYC
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire mss_pkg::mss_cfg_t cfg_in,
  input wire logic [11:0] phase_current_in,
  input wire logic [15:0] auto_handoff_speed_in,
  input wire logic [15:0] speed_ref_in,
  input wire logic [15:0] theta_est_in,
  output mss_pkg::mss_gate_t gate_out,
  output logic gate_pwm_out,
  output logic [15:0] drive_angle_out,
  output logic [15:0] speed_out,
  output logic [11:0] iq_ref_out,
  output logic [2:0] probe_position_out,
  output logic closed_loop_out,
  output mss_pkg::mss_state_t state_out
);
  import mss_pkg::*;

  mss_state_t st_r, st_nxt;
  logic [31:0] tick_cnt_r, tick_cnt_nxt;
  logic [15:0] rate_cnt_r, rate_cnt_nxt;
  logic [15:0] pcnt_r, pcnt_nxt;
  logic [15:0] best_r, best_nxt;
  logic [2:0] idx_r, idx_nxt;
  logic [2:0] best_idx_r, best_idx_nxt;
  logic [31:0] ang_r, ang_nxt;
  logic [32:0] lap_r, lap_nxt;
  logic [15:0] t_r, t_nxt;
  logic [15:0] spd_r, spd_nxt;
  logic [11:0] iq_r, iq_nxt;
  logic [15:0] err_r, err_nxt;
  logic [15:0] angle_out_nxt;
  mss_gate_t gate_nxt;
  logic pwm_nxt;
  logic cl_nxt;

  logic tick;
  logic rate_tick;
  logic [15:0] thr;
  logic skip_decay;
  logic [47:0] prof;
  logic [15:0] prof_sat;

  // timebase ticks and handoff decisions
  // both counters run free, so a new pattern may wait up to a rate period
  assign tick = (tick_cnt_r == 32'(OL_TICK_CYC - 1));
  assign rate_tick = (rate_cnt_r == 16'h0);
  assign thr = cfg_in.auto_handoff_enable ? auto_handoff_speed_in
             : cfg_in.handoff_speed_threshold;
  assign skip_decay = {1'b0, speed_ref_in} > {thr, 1'b0};
  // speed profile A1*t + A2*t*t/2
  // operands widened first, else A1*t would wrap at 16 bits
  assign prof = 48'(cfg_in.open_loop_accel_linear_coef) * 48'(t_r)
              + ((48'(cfg_in.open_loop_accel_quadratic_coef) * 48'(t_r)
                 * 48'(t_r)) >> 1);
  assign prof_sat = (prof[47:16] != 32'h0) ? 16'hffff : prof[15:0];

  // next-state and datapath
  always_comb begin
    st_nxt = st_r;
    tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
    rate_cnt_nxt = rate_tick ? cfg_in.probe_pattern_rate
                 : rate_cnt_r - 16'h1;
    pcnt_nxt = pcnt_r;
    best_nxt = best_r;
    idx_nxt = idx_r;
    best_idx_nxt = best_idx_r;
    ang_nxt = ang_r;
    lap_nxt = lap_r;
    t_nxt = t_r;
    spd_nxt = spd_r;
    iq_nxt = iq_r;
    err_nxt = err_r;
    gate_nxt = '0;
    pwm_nxt = 1'b0;
    cl_nxt = 1'b0;
    angle_out_nxt = ang_r[31:16];
    case (st_r)
      MSS_IDLE: begin
        spd_nxt = 16'h0;
        iq_nxt = 12'h0;
        t_nxt = 16'h0;
        lap_nxt = 33'h0;
        err_nxt = 16'h0;
        // every start begins from rest with a fresh profile
        if (start_in) begin
          case (cfg_in.startup_method_select)
            MSS_SEL_PROBE: begin
              st_nxt = MSS_PDRIVE;
              idx_nxt = 3'h0;
              pcnt_nxt = 16'h0;
              best_nxt = 16'hffff;
              best_idx_nxt = 3'h0;
            end
            MSS_SEL_SLOW: begin
              st_nxt = MSS_SLOW;
              ang_nxt = {cfg_in.align_angle, 16'h0};
            end
            default: begin
              st_nxt = MSS_ALIGN1;
              ang_nxt = {cfg_in.align_angle, 16'h0};
            end
          endcase
        end
      end
      MSS_ALIGN1, MSS_ALIGN2: begin
        // dc current on a fixed pattern until the tick after align_time ticks have counted
        iq_nxt = cfg_in.align_current;
        pwm_nxt = 1'b1;
        if (tick) begin
          t_nxt = t_r + 16'h1;
        end
        if (tick && t_r >= cfg_in.align_time) begin
          t_nxt = 16'h0;
          if (st_r == MSS_ALIGN1
              && cfg_in.startup_method_select == MSS_SEL_DALIGN) begin
            st_nxt = MSS_ALIGN2;
            ang_nxt = ang_r + {MSS_ANGLE_90, 16'h0};
          end else begin
            st_nxt = MSS_OPEN;
          end
        end
      end
      MSS_PDRIVE: begin
        // drive pattern and time current rise
        gate_nxt.high = MSS_PAT_HIGH[idx_r];
        gate_nxt.low = MSS_PAT_LOW[idx_r];
        pcnt_nxt = (pcnt_r == 16'hffff) ? pcnt_r : pcnt_r + 16'h1;
        // a pattern that never reaches threshold ends at the count ceiling
        if (phase_current_in >= cfg_in.probe_current_threshold
            || pcnt_r == 16'hffff) begin
          st_nxt = MSS_PWAIT;
          gate_nxt.high = 3'h0;
          gate_nxt.low = (cfg_in.probe_release_select == MSS_REL_RECIRC)
                       ? MSS_PAT_LOW[idx_r] : 3'h0;
          // strict compare: ties keep the earlier pattern
          if (pcnt_r < best_r) begin
            best_nxt = pcnt_r;
            best_idx_nxt = idx_r;
          end
        end
      end
      MSS_PWAIT: begin
        // release and wait for the next pattern rate tick
        // release level stands until then so recirculation can decay
        gate_nxt.low = (cfg_in.probe_release_select == MSS_REL_RECIRC)
                     ? MSS_PAT_LOW[idx_r] : 3'h0;
        if (rate_tick) begin
          pcnt_nxt = 16'h0;
          if (idx_r == MSS_PAT_LAST) begin
            st_nxt = MSS_OPEN;
            ang_nxt = {MSS_PAT_ANGLE[best_idx_r]
                       + cfg_in.probe_drive_advance_angle, 16'h0};
          end else begin
            idx_nxt = idx_r + 3'h1;
            st_nxt = MSS_PDRIVE;
          end
        end
      end
      MSS_SLOW: begin
        // one electrical cycle at fixed slow speed
        spd_nxt = cfg_in.first_cycle_speed;
        iq_nxt = cfg_in.open_loop_current_limit;
        pwm_nxt = 1'b1;
        ang_nxt = ang_r + {16'h0, spd_r};
        lap_nxt = lap_r + {17'h0, spd_r};
        if (lap_r[32]) begin
          // profile is zero at t = 0; keeping the slow speed here could
          // trip the handoff test on the first open-loop cycle
          st_nxt = MSS_OPEN;
          t_nxt = 16'h0;
          spd_nxt = 16'h0;
        end
      end
      MSS_OPEN, MSS_DECAY: begin
        // ramp generator angle, current regulators keep running
        pwm_nxt = 1'b1;
        ang_nxt = ang_r + {16'h0, spd_r};
        if (tick && t_r != 16'hffff) begin
          t_nxt = t_r + 16'h1;
        end
        spd_nxt = prof_sat;
        if (st_r == MSS_OPEN) begin
          iq_nxt = cfg_in.open_loop_current_limit;
          // zero speed never hands off, so a stalled profile stays open
          if (spd_r >= thr && spd_r != 16'h0) begin
            if (cfg_in.torque_current_ramp_enable && !skip_decay) begin
              st_nxt = MSS_DECAY;
            end else begin
              st_nxt = MSS_CLSLOW;
              err_nxt = ang_r[31:16] - theta_est_in;
            end
          end
        end else if (iq_r <= (cfg_in.open_loop_current_limit >> 1)) begin
          // decay floor reached, hand over to the slow closed-loop phase
          st_nxt = MSS_CLSLOW;
          err_nxt = ang_r[31:16] - theta_est_in;
        end else if (tick) begin
          iq_nxt = iq_r - (cfg_in.open_loop_current_limit
                           >> MSS_IQ_DECAY_SHIFT) - 12'h1;
        end
      end
      MSS_CLSLOW: begin
        // angle error fades linearly; speed rises at slow rate
        pwm_nxt = 1'b1;
        angle_out_nxt = theta_est_in + err_r;
        // signed compare so error of either sign shrinks toward zero
        if (tick) begin
          if ($signed(err_r) > $signed(cfg_in.theta_error_ramp_rate)) begin
            err_nxt = err_r - cfg_in.theta_error_ramp_rate;
          end else if ($signed(err_r)
                       < -$signed(cfg_in.theta_error_ramp_rate)) begin
            err_nxt = err_r + cfg_in.theta_error_ramp_rate;
          end else begin
            err_nxt = 16'h0;
          end
          if (17'(spd_r) + 17'(cfg_in.closed_loop_slow_accel)
              < 17'(speed_ref_in)) begin
            spd_nxt = spd_r + cfg_in.closed_loop_slow_accel;
          end else begin
            spd_nxt = speed_ref_in;
          end
        end
        if (err_r == 16'h0) begin
          st_nxt = MSS_CLRUN;
        end
      end
      MSS_CLRUN: begin
        pwm_nxt = 1'b1;
        cl_nxt = 1'b1;
        angle_out_nxt = theta_est_in;
        spd_nxt = speed_ref_in;
      end
      default: begin
        st_nxt = MSS_IDLE;
      end
    endcase
    // dropping start abandons any phase at once, bridges off
    if (!start_in) begin
      st_nxt = MSS_IDLE;
      gate_nxt = '0;
      pwm_nxt = 1'b0;
      cl_nxt = 1'b0;
    end
  end

  // state registers
  // reset loads constants only; best time restarts at its ceiling
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= MSS_IDLE;
      tick_cnt_r <= 32'h0;
      rate_cnt_r <= 16'h0;
      pcnt_r <= 16'h0;
      best_r <= 16'hffff;
      idx_r <= 3'h0;
      best_idx_r <= 3'h0;
      ang_r <= 32'h0;
      lap_r <= 33'h0;
      t_r <= 16'h0;
      spd_r <= 16'h0;
      iq_r <= 12'h0;
      err_r <= 16'h0;
      gate_out <= '0;
      gate_pwm_out <= 1'b0;
      drive_angle_out <= 16'h0;
      closed_loop_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      pcnt_r <= pcnt_nxt;
      best_r <= best_nxt;
      idx_r <= idx_nxt;
      best_idx_r <= best_idx_nxt;
      ang_r <= ang_nxt;
      lap_r <= lap_nxt;
      t_r <= t_nxt;
      spd_r <= spd_nxt;
      iq_r <= iq_nxt;
      err_r <= err_nxt;
      gate_out <= gate_nxt;
      gate_pwm_out <= pwm_nxt;
      drive_angle_out <= angle_out_nxt;
      closed_loop_out <= cl_nxt;
    end
  end

  // registered status views
  // plain views of registers, so each output stands straight from a flop
  assign speed_out = spd_r;
  assign iq_ref_out = iq_r;
  assign probe_position_out = best_idx_r;
  assign state_out = st_r;

endmodule : mss_top

// ### tb/mss_props.sv
// Purpose: port checks for the start-up sequencer
// Assumes: cfg and references held steady during a run
// Notes: bound into mss_top at the foot of this file
module mss_props import mss_pkg::*; #(
  parameter int OL_TICK_CYC = 8
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire mss_cfg_t cfg_in,
  input wire logic [11:0] phase_current_in,
  input wire logic [15:0] auto_handoff_speed_in,
  input wire logic [15:0] speed_ref_in,
  input wire mss_gate_t gate_out,
  input wire logic gate_pwm_out,
  input wire logic [15:0] drive_angle_out,
  input wire logic [15:0] speed_out,
  input wire logic [11:0] iq_ref_out,
  input wire logic [2:0] probe_position_out,
  input wire logic closed_loop_out,
  input wire mss_state_t state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rstn_in);
  logic [2:0] pat_r;
  logic [2:0] pat_nxt;
  mss_state_t prev_r;
  logic [15:0] thr;
  logic skip;
  // threshold in use and decay bypass
  assign thr = cfg_in.auto_handoff_enable ? auto_handoff_speed_in
    : cfg_in.handoff_speed_threshold;
  assign skip = {1'b0, speed_ref_in} > {thr, 1'b0};
  // index of the pattern being driven
  always_comb begin
    pat_nxt = pat_r;
    if (state_out == MSS_IDLE) begin
      pat_nxt = 3'h0;
    end else if (state_out == MSS_PDRIVE && prev_r == MSS_PWAIT) begin
      pat_nxt = pat_r + 3'h1;
    end
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pat_r <= 3'h0;
      prev_r <= MSS_IDLE;
    end else begin
      pat_r <= pat_nxt;
      prev_r <= state_out;
    end
  end
  property p_probe;
    state_out == MSS_IDLE && start_in
      && cfg_in.startup_method_select == MSS_SEL_PROBE
      |=> state_out == MSS_PDRIVE;
  endproperty
  a_probe: assert property (p_probe) else $error("probe not started");
  property p_slow;
    state_out == MSS_IDLE && start_in
      && cfg_in.startup_method_select == MSS_SEL_SLOW
      |=> state_out == MSS_SLOW;
  endproperty
  a_slow: assert property (p_slow) else $error("slow not started");
  property p_align;
    state_out == MSS_IDLE && start_in && !cfg_in.startup_method_select[1]
      |=> state_out == MSS_ALIGN1;
  endproperty
  a_align: assert property (p_align) else $error("no align");
  property p_order;
    state_out == MSS_PDRIVE && prev_r == MSS_PDRIVE
      |-> gate_out.high == MSS_PAT_HIGH[pat_r]
      && gate_out.low == MSS_PAT_LOW[pat_r];
  endproperty
  a_order: assert property (p_order) else $error("bad pattern");
  property p_release;
    state_out == MSS_PDRIVE && start_in
      && phase_current_in >= cfg_in.probe_current_threshold
      |=> state_out == MSS_PWAIT && gate_out.high == 3'h0
      && gate_out.low == (cfg_in.probe_release_select ? 3'h0
      : MSS_PAT_LOW[pat_r]);
  endproperty
  a_release: assert property (p_release) else $error("bad release");
  property p_open_angle;
    $past(state_out) == MSS_PWAIT && state_out == MSS_OPEN
      |=> drive_angle_out == MSS_PAT_ANGLE[probe_position_out]
      + cfg_in.probe_drive_advance_angle;
  endproperty
  a_open_angle: assert property (p_open_angle) else $error("bad angle");
  property p_ol_iq;
    state_out == MSS_OPEN && $past(state_out) == MSS_OPEN
      |-> iq_ref_out == cfg_in.open_loop_current_limit && gate_pwm_out
      && gate_out == 6'h0;
  endproperty
  a_ol_iq: assert property (p_ol_iq) else $error("bad open drive");
  property p_ol_speed;
    state_out == MSS_OPEN && $past(state_out) == MSS_OPEN
      |-> speed_out >= $past(speed_out);
  endproperty
  a_ol_speed: assert property (p_ol_speed) else $error("speed fell");
  property p_slow_spd;
    state_out == MSS_SLOW && $past(state_out) == MSS_SLOW
      |-> speed_out == cfg_in.first_cycle_speed;
  endproperty
  a_slow_spd: assert property (p_slow_spd) else $error("bad slow");
  property p_handoff;
    state_out == MSS_OPEN && speed_out >= thr && speed_out != 16'h0
      |-> ##[1:2] state_out != MSS_OPEN;
  endproperty
  a_handoff: assert property (p_handoff) else $error("no handoff");
  property p_decay;
    $past(state_out) == MSS_OPEN && state_out inside {MSS_DECAY, MSS_CLSLOW}
      |-> (state_out == MSS_DECAY)
      == (cfg_in.torque_current_ramp_enable && !skip);
  endproperty
  a_decay: assert property (p_decay) else $error("bad decay");
  property p_clflag;
    $rose(closed_loop_out) |-> $past(state_out) == MSS_CLRUN;
  endproperty
  a_clflag: assert property (p_clflag) else $error("early loop");
  c_decay: cover property (state_out == MSS_DECAY);
  c_dalign: cover property (state_out == MSS_ALIGN2);
  c_recirc: cover property (state_out == MSS_PWAIT && gate_out.low != 3'h0);
  c_closed: cover property (closed_loop_out);
endmodule : mss_props

bind mss_top mss_props #(.OL_TICK_CYC(OL_TICK_CYC)) u_props (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .start_in(start_in),
  .cfg_in(cfg_in), .phase_current_in(phase_current_in),
  .auto_handoff_speed_in(auto_handoff_speed_in),
  .speed_ref_in(speed_ref_in), .gate_out(gate_out),
  .gate_pwm_out(gate_pwm_out), .drive_angle_out(drive_angle_out),
  .speed_out(speed_out), .iq_ref_out(iq_ref_out),
  .probe_position_out(probe_position_out),
  .closed_loop_out(closed_loop_out), .state_out(state_out));

// ### tb/mss_motor.sv
// Purpose: motor and bridge stand-in for probing
// Assumes: one pattern has the lowest inductance
// Notes: sensed current restarts at each new pattern
module mss_motor import mss_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire mss_gate_t gate_in,
  input wire logic [2:0] fast_in,
  output logic [11:0] cur_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] cur_nxt;
  mss_gate_t last_r;
  // rise when driven, slow fall on recirculation, none in hi-z
  always_comb begin
    cur_nxt = 12'h0;
    if (gate_in.high != 3'h0) begin
      cur_nxt = ((gate_in == last_r) ? cur_out : 12'h0)
        + ((gate_in == {MSS_PAT_HIGH[fast_in], MSS_PAT_LOW[fast_in]})
        ? 12'h8 : 12'h4);
    end else if (gate_in.low != 3'h0 && cur_out > 12'h20) begin
      cur_nxt = cur_out - 12'h20;
    end
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_out <= 12'h0;
      last_r <= '0;
    end else begin
      cur_out <= cur_nxt;
      last_r <= gate_in;
    end
  end
endmodule : mss_motor

// ### tb/tb.sv
// Purpose: self-checking bench for the start-up sequencer
// Assumes: open-loop tick shortened to 8 cycles
// Notes: rows run whole start-ups; abort and reset follow
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mss_pkg::*;
  typedef struct packed {
    logic [1:0] sel;
    logic rel;
    logic [2:0] fast;
    logic ramp;
    logic auto;
    logic [15:0] spd;
    logic [9:0] mask;
  } mss_row_t;
  localparam mss_row_t ROWS [6] = '{
    '{2'h2, 1'b0, 3'h3, 1'b1, 1'b0, 16'h1800, 10'h3d8},
    '{2'h2, 1'b1, 3'h0, 1'b1, 1'b0, 16'h2001, 10'h358},
    '{2'h2, 1'b0, 3'h5, 1'b0, 1'b0, 16'h1800, 10'h358},
    '{2'h0, 1'b0, 3'h0, 1'b1, 1'b0, 16'h1800, 10'h3c2},
    '{2'h1, 1'b0, 3'h0, 1'b1, 1'b0, 16'h2000, 10'h3c6},
    '{2'h2, 1'b1, 3'h1, 1'b1, 1'b1, 16'h1800, 10'h358}};
  logic mclk_in = 1'b0;
  logic rstn_in;
  logic start_in;
  mss_cfg_t cfg;
  logic [11:0] cur;
  logic [15:0] spd_ref;
  logic [2:0] fast;
  mss_gate_t gate;
  logic pwm;
  logic [15:0] speed;
  logic [2:0] pos;
  logic cl;
  mss_state_t state;
  logic [15:0] seen;
  int n_mismatch = 0;
  int n_compared = 0;
  always #10 mclk_in = ~mclk_in;
  mss_top #(.OL_TICK_CYC(8)) dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .start_in(start_in), .cfg_in(cfg), .phase_current_in(cur),
    .auto_handoff_speed_in(16'h0800), .speed_ref_in(spd_ref),
    .theta_est_in(16'h0), .gate_out(gate), .gate_pwm_out(pwm),
    .drive_angle_out(), .speed_out(speed), .iq_ref_out(),
    .probe_position_out(pos), .closed_loop_out(cl), .state_out(state));
  mss_motor u_motor (.mclk_in(mclk_in), .rstn_in(rstn_in), .gate_in(gate),
    .fast_in(fast), .cur_out(cur));
  // compare and count
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  // collect states until closed loop, bounded
  task run;
    int k;
    seen = 16'h0;
    for (k = 0; k < 3000 && cl !== 1'b1; k++) begin
      @(negedge mclk_in);
      seen[state] = 1'b1;
    end
    if (cl !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask : run
  initial begin
    rstn_in = 1'b0;
    start_in = 1'b0;
    spd_ref = 16'h1800;
    fast = 3'h0;
    cfg = '{2'h2, 1'b0, 16'h001f, 12'h040, 16'h2000, 16'h0, 16'h1, 12'h080,
      16'h8000, 12'h100, 16'h0100, 16'h0080, 1'b0, 16'h1000, 1'b0,
      16'h1000, 16'h0100};
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    // whole start-ups, one per row
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_in);
      cfg.startup_method_select <= ROWS[i].sel;
      cfg.probe_release_select <= ROWS[i].rel;
      cfg.torque_current_ramp_enable <= ROWS[i].ramp;
      cfg.auto_handoff_enable <= ROWS[i].auto;
      spd_ref <= ROWS[i].spd;
      fast <= ROWS[i].fast;
      start_in <= 1'b1;
      run();
      chk("states", {6'h0, ROWS[i].mask}, seen & 16'h3fe);
      if (ROWS[i].sel == MSS_SEL_PROBE) begin
        chk("position", {13'h0, ROWS[i].fast}, {13'h0, pos});
      end
      @(posedge mclk_in);
      start_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
    end
    // slow first cycle, then abort mid-cycle
    cfg.startup_method_select <= MSS_SEL_SLOW;
    start_in <= 1'b1;
    repeat (5) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("slow state", {12'h0, MSS_SLOW}, {12'h0, state});
    chk("slow speed", cfg.first_cycle_speed, speed);
    @(posedge mclk_in);
    start_in <= 1'b0;
    @(posedge mclk_in);
    @(negedge mclk_in);
    chk("abort", 16'h0, {11'h0, pwm, state});
    // reset in mid-probe
    @(posedge mclk_in);
    cfg.startup_method_select <= MSS_SEL_PROBE;
    start_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    rstn_in <= 1'b0;
    @(negedge mclk_in);
    chk("reset", 16'h0, {4'h0, cl, pwm, gate, state});
    // release with start still high: probing restarts from the first edge
    @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("restart", {12'h0, MSS_PDRIVE}, {12'h0, state});
    results();
  end
endmodule : tb
